// >>> core/psram_pkg.sv
// ****************************************************************
// Shared constants and types for the pseudo-static RAM device side
// ****************************************************************
package psram_pkg;

    // ****************************************************************
    // Geometry
    // ****************************************************************
    localparam int ADDR_W = 8;                 // Word address width of the array
    localparam int DATA_W = 16;                // Data bus width
    localparam int MEM_DEPTH = 256;            // Words held in the array
    localparam int FIFO_DEPTH = 8;             // Read path buffer depth

    // ****************************************************************
    // Burst configuration
    // ****************************************************************
    localparam logic [3:0] LATENCY = 4'h5;     // Clocks from burst start to first data
    localparam logic [3:0] BURST_LEN = 4'h4;   // Words per burst

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_PS = 25000;      // Reference clock period
    localparam int BURST_CYCLE_MAX_NS = 2500;  // Longest burst cycle time, 2.5 us
    localparam int BURST_CYCLE_MAX_CLKS = (BURST_CYCLE_MAX_NS * 1000) / CLK_PERIOD_PS;
    localparam int BURST_END_GAP_PS = 7000;    // Burst end to next address valid
    localparam int BURST_END_GAP_CLKS =
        (BURST_END_GAP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [3:0] WRITE_RECOVERY_CLKS = 4'h1; // Write-low recovery

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_LAT   = 4'b0010,
        ST_READ  = 4'b0100,
        ST_WRITE = 4'b1000
    } burst_state_t;

    // Host-side strobes gathered together
    typedef struct packed {
        logic cs_n;
        logic address_valid_n;
        logic oe_n;
        logic we_n;
    } ctrl_pins_t;

    // One word in the read path
    typedef struct packed {
        logic [DATA_W-1:0] data;
    } word_t;

endpackage

// >>> core/psram_fifo.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Word FIFO with valid/ready on both sides
// ****************************************************************
module psram_fifo
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // Flush on deselect
    input wire logic flush
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];        // Storage
    logic [AW:0] wr_r;                    // Write pointer with wrap bit
    logic [AW:0] rd_r;                    // Read pointer with wrap bit
    wire do_wr = in_valid && in_ready;
    wire do_rd = out_valid && out_ready;

    // Honest full and empty from wrap bits
    assign in_ready = !((wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]));
    assign out_valid = (wr_r != rd_r);
    assign out_data = mem[rd_r[AW-1:0]];

    // Pointers
    always_ff @(posedge clk)
    begin
        if (rst || flush)
        begin
            wr_r <= '0;
            rd_r <= '0;
        end
        else
        begin
            if (do_wr)
                wr_r <= wr_r + 1'b1;
            if (do_rd)
                rd_r <= rd_r + 1'b1;
        end
    end

    // Storage write, no reset needed on data
    always_ff @(posedge clk)
    begin
        if (do_wr)
            mem[wr_r[AW-1:0]] <= in_data;
    end
endmodule
`default_nettype wire

// >>> core/psram_core.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Wait goes low on select or address edge
// - Wait rises one clock before latency expires
// - Wait floats when chip select rises
// - Burst starts on first edge, valid low
// - Stalled read holds word, resumes it first
module psram_core
import psram_pkg::*;
(
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    // Burst clock enable from the host; low means the burst clock is halted
    input wire logic BURST_CLK_EN,
    // Control strobes, all active low
    input wire logic CS_N,
    input wire logic ADDRESS_VALID_N,
    input wire logic OE_N,
    input wire logic WE_N,
    // Address and data
    input wire logic [ADDR_W-1:0] ADDR,
    input wire logic [DATA_W-1:0] DQ_IN,
    output logic [DATA_W-1:0] DQ_OUT,
    output logic DQ_OE_N,
    // Wait pin, low while data not ready, floated when deselected
    output logic WAIT_OUT,
    output logic WAIT_OE_N,
    // Status
    output logic BURST_BUSY,
    output logic BURST_OVERRUN
);
    // ****************************************************************
    // Storage and state
    // ****************************************************************
    logic [DATA_W-1:0] mem [MEM_DEPTH];     // Array contents
    ctrl_pins_t pins;                       // Grouped strobes
    ctrl_pins_t pins_prev_r;                // Strobes one clock ago
    burst_state_t state_r;                  // Burst sequencer
    burst_state_t state_nxt;
    logic [3:0] lat_cnt_r;                  // Latency countdown
    logic [3:0] beat_cnt_r;                 // Words left in burst
    logic [ADDR_W-1:0] addr_r;              // Current burst address
    logic is_write_r;                       // Burst is a write
    logic wait_r;                           // Wait level
    logic [DATA_W-1:0] dq_r;                // Output data register
    logic dq_oe_n_r;
    logic [15:0] cycle_cnt_r;               // Burst length watchdog
    logic overrun_r;
    logic async_we_prev_r;                  // Async write strobe history

    assign pins = '{cs_n: CS_N, address_valid_n: ADDRESS_VALID_N, oe_n: OE_N, we_n: WE_N};

    // ****************************************************************
    // Decode
    // ****************************************************************
    wire clk_on = BURST_CLK_EN;
    wire selected = !pins.cs_n;
    // Falling edges of select or address valid restart the wait
    wire fall_cs = pins_prev_r.cs_n && !pins.cs_n;
    wire fall_address_valid = pins_prev_r.address_valid_n && !pins.address_valid_n;
    // Burst start: first enabled edge with address valid low, idle only
    wire start = selected && !pins.address_valid_n && clk_on && (state_r == ST_IDLE);
    wire lat_done = (lat_cnt_r == 4'h1);
    wire last_beat = (beat_cnt_r == 4'h1);
    // Async write when the burst clock is idle and write strobe falls back high
    wire async_wr = selected && (state_r == ST_IDLE) && !clk_on && !async_we_prev_r && pins.we_n;

    // ****************************************************************
    // Read path FIFO; core pushes fetched words, pin side drains
    // ****************************************************************
    word_t fifo_in;
    word_t fifo_out;
    logic fifo_in_ready;
    logic fifo_out_valid;
    wire read_beat = (state_r == ST_READ) && clk_on;
    // Prefetch keeps the buffer ahead of the pins
    wire fetch = (state_r != ST_IDLE) && !is_write_r && fifo_in_ready;
    logic [ADDR_W-1:0] fetch_addr_r;
    assign fifo_in.data = mem[fetch_addr_r];
    wire pop = read_beat && fifo_out_valid;

    psram_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo
    (
        .clk(REF_CLK),
        .rst(RST),
        .in_valid(fetch),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in.data),
        .out_valid(fifo_out_valid),
        .out_ready(read_beat),
        .out_data(fifo_out.data),
        .flush(!selected)
    );

    // ****************************************************************
    // Sequencer next state
    // ****************************************************************
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:
                if (start)
                    state_nxt = ST_LAT;
            ST_LAT:
                if (!selected)
                    state_nxt = ST_IDLE;
                else if (clk_on && lat_done)
                    state_nxt = is_write_r ? ST_WRITE : ST_READ;
            ST_READ, ST_WRITE:
                if (!selected || (clk_on && last_beat))
                    state_nxt = ST_IDLE;
            default:
                state_nxt = ST_IDLE;
        endcase
    end

    // ****************************************************************
    // Sequencer registers
    // ****************************************************************
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            state_r <= ST_IDLE;
            pins_prev_r <= '{cs_n: 1'b1, address_valid_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
            async_we_prev_r <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
            pins_prev_r <= pins;
            async_we_prev_r <= pins.we_n;
        end
    end

    // Counters and burst address; clock halt freezes them, not the prefetch address
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            lat_cnt_r <= '0;
            beat_cnt_r <= '0;
            addr_r <= '0;
            fetch_addr_r <= '0;
            is_write_r <= 1'b0;
        end
        else if (start)
        begin
            lat_cnt_r <= LATENCY;
            beat_cnt_r <= BURST_LEN;
            addr_r <= ADDR;
            fetch_addr_r <= ADDR;
            is_write_r <= !pins.we_n;
        end
        else
        begin
            if (clk_on && state_r == ST_LAT)
                lat_cnt_r <= lat_cnt_r - 4'h1;
            if (clk_on && (state_r == ST_READ || state_r == ST_WRITE))
            begin
                beat_cnt_r <= beat_cnt_r - 4'h1;
                addr_r <= addr_r + 1'b1;
            end
            if (fetch)
                fetch_addr_r <= fetch_addr_r + 1'b1;
        end
    end

    // Array writes: burst beats and asynchronous writes
    always_ff @(posedge REF_CLK)
    begin
        if (state_r == ST_WRITE && clk_on && selected)
            mem[addr_r] <= DQ_IN;
        else if (async_wr)
            mem[ADDR] <= DQ_IN;
    end

    // ****************************************************************
    // Wait pin
    // ****************************************************************
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
            wait_r <= 1'b0;
        else if (fall_cs || fall_address_valid)
            wait_r <= 1'b0;
        else if (state_r == ST_LAT && clk_on && lat_cnt_r == 4'h2)
            wait_r <= 1'b1;
        else if (state_r == ST_IDLE)
            wait_r <= 1'b0;
    end
    assign WAIT_OUT = wait_r;
    assign WAIT_OE_N = pins.cs_n;

    // ****************************************************************
    // Read data output; register holds last word while halted
    // ****************************************************************
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            dq_r <= '0;
            dq_oe_n_r <= 1'b1;
        end
        else
        begin
            if (pop)
                dq_r <= fifo_out.data;
            dq_oe_n_r <= !(selected && !pins.oe_n && !is_write_r && state_r == ST_READ);
        end
    end
    assign DQ_OUT = dq_r;
    assign DQ_OE_N = dq_oe_n_r;

    // ****************************************************************
    // Burst cycle watchdog, flags a host that overstays
    // ****************************************************************
    always_ff @(posedge REF_CLK)
    begin
        if (RST)
        begin
            cycle_cnt_r <= '0;
            overrun_r <= 1'b0;
        end
        else if (state_r == ST_IDLE)
            cycle_cnt_r <= '0;
        else
        begin
            cycle_cnt_r <= cycle_cnt_r + 16'h1;
            if (cycle_cnt_r == 16'(BURST_CYCLE_MAX_CLKS))
                overrun_r <= 1'b1;
        end
    end
    assign BURST_BUSY = (state_r != ST_IDLE);
    assign BURST_OVERRUN = overrun_r;
endmodule
`default_nettype wire

// >>> verification/psram_core_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Pin-level checker for the device side
// ****************************************************************
module psram_core_monitor
import psram_pkg::*;
(
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    // Host strobes
    input wire logic BURST_CLK_EN,
    input wire logic CS_N,
    input wire logic ADDRESS_VALID_N,
    // Device answer
    input wire logic [DATA_W-1:0] DQ_OUT,
    input wire logic DQ_OE_N,
    input wire logic WAIT_OUT,
    input wire logic WAIT_OE_N,
    input wire logic BURST_BUSY
);
    // Burst accepted on this edge
    wire start = !CS_N && !ADDRESS_VALID_N && BURST_CLK_EN && !BURST_BUSY;
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RST);
    // Reset values hold even while reset is applied
    property p_rst;
        disable iff (1'b0) RST |=> !WAIT_OUT && DQ_OE_N && !BURST_BUSY;
    endproperty
    a_rst: assert property (p_rst) else $error("reset values wrong");
    property p_wait_low;
        $fell(CS_N) || (!CS_N && $fell(ADDRESS_VALID_N)) |=> !WAIT_OUT;
    endproperty
    a_wait_low: assert property (p_wait_low) else $error("wait not low");
    property p_wait_early;
        start |=> !WAIT_OUT [*3];
    endproperty
    a_wait_early: assert property (p_wait_early) else $error("wait early");
    // Only judged when the burst runs undisturbed through latency
    property p_wait_rise;
        start ##1 (!CS_N && BURST_CLK_EN) [*4] |-> !WAIT_OUT ##1 WAIT_OUT;
    endproperty
    a_wait_rise: assert property (p_wait_rise) else $error("wait late");
    property p_float;
        CS_N |-> WAIT_OE_N;
    endproperty
    a_float: assert property (p_float) else $error("wait driven");
    property p_abort;
        CS_N && BURST_BUSY |=> !BURST_BUSY;
    endproperty
    a_abort: assert property (p_abort) else $error("abort ignored");
    property p_first_edge;
        $rose(BURST_BUSY) |-> $past(start);
    endproperty
    a_first_edge: assert property (p_first_edge) else $error("bad start");
    property p_hold;
        BURST_BUSY && !CS_N && !BURST_CLK_EN |=> $stable(DQ_OUT);
    endproperty
    a_hold: assert property (p_hold) else $error("word lost in halt");
    c_start: cover property (start);
    c_halt: cover property (BURST_BUSY && !BURST_CLK_EN);
    c_abort: cover property (CS_N && BURST_BUSY);
endmodule
bind psram_core psram_core_monitor mon_u (.REF_CLK(REF_CLK), .RST(RST),
    .BURST_CLK_EN(BURST_CLK_EN), .CS_N(CS_N), .ADDRESS_VALID_N(ADDRESS_VALID_N),
    .DQ_OUT(DQ_OUT), .DQ_OE_N(DQ_OE_N), .WAIT_OUT(WAIT_OUT),
    .WAIT_OE_N(WAIT_OE_N), .BURST_BUSY(BURST_BUSY));
`default_nettype wire

// >>> verification/psram_host.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Host controller model on the device pins
// ****************************************************************
module psram_host
import psram_pkg::*;
(
    // Clock
    input wire logic clk,
    // Strobes to the device
    output logic en,
    output logic cs_n,
    output logic address_valid_n,
    output logic oe_n,
    output logic we_n,
    output logic [ADDR_W-1:0] addr,
    output logic [DATA_W-1:0] dq,
    // Device answer
    input wire logic [DATA_W-1:0] dq_out,
    input wire logic dq_oe_n,
    input wire logic wait_out
);
    logic [DATA_W-1:0] rd_q[$];  // Words gathered this burst
    logic [DATA_W-1:0] last;     // Last word seen, stale value masked
    logic wait_seen;             // Wait high before first beat
    initial
    begin
        {en, cs_n, address_valid_n, oe_n, we_n} = 5'h0f;
        addr = 8'h00;
        dq = 16'h0000;
    end
    // Settled at the falling edge; a held word is not counted twice
    // Read only once wait shows data
    always @(negedge clk)
        if (!cs_n && !dq_oe_n && wait_out && dq_out !== last)
        begin
            rd_q.push_back(dq_out);
            last = dq_out;
        end
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    // Idle gap, clock halted, lines toggling
    task automatic release_bus();
        {en, cs_n, address_valid_n, oe_n, we_n} = 5'h0f;
        repeat (BURST_END_GAP_CLKS + 1)
        begin
            dq = ~dq;
            addr = ~addr;
            tick();
        end
    endtask
    // Burst: start, latency, beats, then release
    task automatic burst(input logic wr, input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d, input int hold, input int halt, input int cut);
        last = dq_out;
        rd_q.delete();
        {en, cs_n, address_valid_n, oe_n, we_n} = {4'h8, !wr};
        oe_n = wr;
        addr = a;
        // Address valid may stay low over several edges
        repeat (hold) tick();
        address_valid_n = 1;
        addr = ~a;
        if (cut > 0)
        begin
            repeat (cut) tick();
            cs_n = 1;
            return;
        end
        repeat (6 - hold) tick();
        // Data moves only once wait is high
        wait_seen = wait_out;
        for (int i = 0; i < (wr ? 5 : 20 + halt) && rd_q.size() < 4; i++)
        begin
            // Write data only after wait was seen high
            dq = (wr && i < 4 && wait_seen) ? d + DATA_W'(i) : ~dq;
            en = !(i >= 2 && i < 2 + halt);
            tick();
        end
        // Burst stays far below 2.5 us unless a long halt is asked for
        release_bus();
    endtask
    task automatic awrite(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
        input logic latch);
        {en, cs_n, address_valid_n} = 3'h0;
        addr = a;
        dq = d;
        tick();
        address_valid_n = latch;
        we_n = 0;
        tick();
        we_n = 1;
        repeat (WRITE_RECOVERY_CLKS + 1) tick();
        release_bus();
    endtask
endmodule
`default_nettype wire

// >>> verification/psram_read_write_transition_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Bench: host model against the device core
// ****************************************************************
module psram_read_write_transition_bench
import psram_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    int n_errors = 0;
    int cmp_count = 0;
    wire logic en, cs_n, address_valid_n, oe_n, we_n, dq_oe_n, wait_out, wait_oe_n, busy, ovr;
    wire logic [ADDR_W-1:0] addr;
    wire logic [DATA_W-1:0] dq, dq_out;
    // 40 MHz clock
    always #12.5 clk = ~clk;
    psram_core dut_u (.REF_CLK(clk), .RST(rst), .BURST_CLK_EN(en), .CS_N(cs_n),
        .ADDRESS_VALID_N(address_valid_n), .OE_N(oe_n), .WE_N(we_n), .ADDR(addr), .DQ_IN(dq),
        .DQ_OUT(dq_out), .DQ_OE_N(dq_oe_n), .WAIT_OUT(wait_out), .WAIT_OE_N(wait_oe_n),
        .BURST_BUSY(busy), .BURST_OVERRUN(ovr));
    psram_host host_u (.clk(clk), .en(en), .cs_n(cs_n), .address_valid_n(address_valid_n), .oe_n(oe_n),
        .we_n(we_n), .addr(addr), .dq(dq), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
        .wait_out(wait_out));
    task automatic check(input string what, input logic [DATA_W-1:0] seen,
        input logic [DATA_W-1:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Four read words in order
    task automatic chk_rd(input logic [DATA_W-1:0] d0, d1, d2, d3);
        check("count", DATA_W'(host_u.rd_q.size()), 16'h0004);
        check("word0", host_u.rd_q[0], d0);
        check("word1", host_u.rd_q[1], d1);
        check("word2", host_u.rd_q[2], d2);
        check("word3", host_u.rd_q[3], d3);
    endtask
    task automatic t_reset();
        check("wait", {15'h0, wait_out}, 16'h0000);
        check("dq_oe", {15'h0, dq_oe_n}, 16'h0001);
        check("busy", {15'h0, busy}, 16'h0000);
        $display("test reset done");
    endtask
    task automatic t_write_read();
        host_u.burst(1'b1, 8'h10, 16'h1000, 1, 0, 0);
        check("wait_w", {15'h0, host_u.wait_seen}, 16'h0001);
        host_u.burst(1'b0, 8'h10, 16'h0000, 1, 0, 0);
        check("wait_r", {15'h0, host_u.wait_seen}, 16'h0001);
        chk_rd(16'h1000, 16'h1001, 16'h1002, 16'h1003);
        $display("test write_read done");
    endtask
    task automatic t_async();
        host_u.burst(1'b1, 8'h20, 16'h2000, 1, 0, 0);
        host_u.burst(1'b0, 8'h20, 16'h0000, 1, 0, 0);
        host_u.awrite(8'h21, 16'h2a2a, 1'b1);
        host_u.awrite(8'h22, 16'h2b2b, 1'b0);
        host_u.burst(1'b0, 8'h20, 16'h0000, 1, 0, 0);
        chk_rd(16'h2000, 16'h2a2a, 16'h2b2b, 16'h2003);
        host_u.burst(1'b1, 8'h20, 16'h4000, 1, 0, 0);
        $display("test async done");
    endtask
    task automatic t_suspend();
        host_u.burst(1'b0, 8'h20, 16'h0000, 3, 3, 0);
        chk_rd(16'h4000, 16'h4001, 16'h4002, 16'h4003);
        $display("test suspend done");
    endtask
    task automatic t_abort();
        host_u.burst(1'b0, 8'h10, 16'h0000, 1, 0, 2);
        host_u.tick();
        check("float", {15'h0, wait_oe_n}, 16'h0001);
        check("idle", {15'h0, busy}, 16'h0000);
        host_u.release_bus();
        host_u.burst(1'b0, 8'h10, 16'h0000, 1, 0, 0);
        chk_rd(16'h1000, 16'h1001, 16'h1002, 16'h1003);
        check("overrun", {15'h0, ovr}, 16'h0000);
        $display("test abort done");
    endtask
    // Long halt overstays the burst cycle; only a reset clears the sticky flag
    task automatic t_overrun();
        host_u.burst(1'b0, 8'h20, 16'h0000, 1, BURST_CYCLE_MAX_CLKS, 0);
        chk_rd(16'h4000, 16'h4001, 16'h4002, 16'h4003);
        check("overrun_set", {15'h0, ovr}, 16'h0001);
        rst = 1'b1;
        repeat (2) host_u.tick();
        rst = 1'b0;
        host_u.tick();
        check("overrun_clr", {15'h0, ovr}, 16'h0000);
        check("busy_clr", {15'h0, busy}, 16'h0000);
        $display("test overrun done");
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Watchdog, far beyond the few hundred cycles needed
    initial
    begin
        #100000;
        n_errors++;
        end_of_test();
    end
    initial
    begin
        repeat (6) @(posedge clk);
        #1 rst = 1'b0;
        host_u.tick();
        t_reset();
        t_write_read();
        t_async();
        t_suspend();
        t_abort();
        t_overrun();
        end_of_test();
    end
endmodule
`default_nettype wire
